/* rtl/mqe_bcast_buf.sv */
// store-and-forward broadcast buffer for one egress port
`timescale 1ns/1ps
`default_nettype none
module mqe_bcast_buf
    import mqe_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // fill side from the work queue
    input  wire logic              wr_valid,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              wr_eop,
    input  wire logic [PRIO_W-1:0] wr_prio,
    input  wire logic              pend,
    output logic                   space,
    // drain side to the egress port
    input  wire logic              eg_ready,
    output logic                   eg_req,
    output logic                   eg_valid,
    output logic [DATA_W-1:0]      eg_data,
    output logic                   eg_eop,
    output logic [PRIO_W-1:0]      eg_prio
);
    logic [DATA_W-1:0]   mem [BB_DEPTH_W];     // packet words
    logic [PRIO_W:0]     tag_mem [BB_DEPTH_W]; // eop and priority
    logic [BB_PTR_W-1:0] wr_ptr_reg, rd_ptr_reg, cnt_reg, cnt_next;
    logic [BB_PKT_W-1:0] pkts_reg, pkts_next;  // complete copies held
    logic                rd_en, rd_eop;

    // only whole copies leave, oldest first
    assign rd_en  = eg_ready && pkts_reg != '0; // RQ10 RQ9
    assign rd_eop = tag_mem[rd_ptr_reg][PRIO_W];
    assign cnt_next  = cnt_reg + BB_PTR_W'(wr_valid) - BB_PTR_W'(rd_en);
    assign pkts_next = pkts_reg + BB_PKT_W'(wr_valid && wr_eop)
                     - BB_PKT_W'(rd_en && rd_eop);

    // storage at the circular write pointer
    always_ff @(posedge ref_clk)
    begin
        if (wr_valid)
        begin
            mem[wr_ptr_reg]     <= wr_data;
            tag_mem[wr_ptr_reg] <= {wr_eop, wr_prio};
        end
    end

    // occupancy and space report, counting the word still in flight
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
            pkts_reg   <= '0;
            space      <= 1'b0;
            eg_req     <= 1'b0;
        end
        else
        begin
            if (wr_valid)
                wr_ptr_reg <= (wr_ptr_reg == BB_LAST_C) ? '0 : wr_ptr_reg + 6'h01;
            if (rd_en)
                rd_ptr_reg <= (rd_ptr_reg == BB_LAST_C) ? '0 : rd_ptr_reg + 6'h01;
            cnt_reg  <= cnt_next;
            pkts_reg <= pkts_next;
            // a word in flight may close a copy, so it counts against the copy limit
            space    <= (BB_DEPTH_C - cnt_next - BB_PTR_W'(pend)) >= BB_ROOM_C
                        && (pkts_next + BB_PKT_W'(pend)) < BB_PKTS_C; // RQ12 RQ11
            eg_req   <= pkts_next != '0;          // RQ23
        end
    end

    // egress word stage
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            eg_valid <= 1'b0;
            eg_data  <= '0;
            eg_eop   <= 1'b0;
            eg_prio  <= '0;
        end
        else
        begin
            eg_valid <= rd_en;
            eg_data  <= mem[rd_ptr_reg];
            eg_eop   <= rd_en && rd_eop;
            eg_prio  <= tag_mem[rd_ptr_reg][PRIO_W-1:0];
        end
    end

    // space is never shown while every word is taken
    property p_buf_bound;
        @(posedge ref_clk) disable iff (rst)
        space |-> cnt_reg < BB_DEPTH_C;
    endproperty
    a_buf_bound : assert property (p_buf_bound) else $error("space shown when full"); // RQ12

    // a word only leaves while a whole copy is held
    property p_whole_copy;
        @(posedge ref_clk) disable iff (rst)
        eg_valid |-> $past(pkts_reg) != '0;
    endproperty
    a_whole_copy : assert property (p_whole_copy) else $error("partial copy sent"); // RQ10
endmodule
`default_nettype wire

/* rtl/mqe_engine.sv */
// multicast work queue with per-egress broadcast buffers
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// [RQ1] queue takes ingress ports only, never buffers
// [RQ2] strict priority, round robin within priority
// [RQ3] queue releases in arrival order, no watermarks
// [RQ4] queue always cuts packets through
// [RQ5] queue is circular, packets start anywhere
// [RQ6] seven largest or 245 smallest packets
// [RQ7] no acceptance below one largest packet space
// [RQ8] broadcast buffer fed only by queue
// [RQ9] broadcast buffer strictly first in first out
// [RQ10] copy offered only once fully stored
// [RQ11] eight copies, rounded total under 280 bytes
// [RQ12] space flag means at least 8 bytes
// [RQ13] no reordering on any output
// [RQ14] sources should use one multicast priority
// [RQ15] fabric runs packets back to back
// [RQ16] arbitration delay only after idle
// [RQ17] slower ports should avoid cut-through
// [RQ18] group hit steers packet, else lookup
// [RQ19] eight groups, each with own mask
// [RQ20] never copy back to arrival port
// [RQ21] egress takes copies by priority, favour select
// [RQ22] copies written to all buffers together
// [RQ23] egress requests only after all copies complete
// [RQ24] pause while any target lacks space
module mqe_engine
    import mqe_pkg::*;
(
    // clock and reset
    input  wire logic                                  ref_clk,
    input  wire logic                                  rst,
    // ingress packet requests
    input  wire logic [MQE_NP-1:0]                     in_req,
    input  wire logic [MQE_NP-1:0][PRIO_W-1:0]         in_prio,
    input  wire logic [MQE_NP-1:0][DID_W-1:0]          in_dest_id,
    input  wire logic [MQE_NP-1:0][TT_W-1:0]           in_ttype,
    // ingress packet words
    input  wire logic [MQE_NP-1:0]                     in_valid,
    input  wire logic [MQE_NP-1:0][DATA_W-1:0]         in_data,
    input  wire logic [MQE_NP-1:0]                     in_eop,
    // ingress answers
    output logic      [MQE_NP-1:0]                     in_mc_hit,
    output logic      [MQE_NP-1:0]                     in_grant,
    output logic                                       in_space_ok,
    // group table
    input  wire logic [NUM_GROUPS-1:0]                 grp_valid,
    input  wire logic [NUM_GROUPS-1:0][DID_W-1:0]      grp_dest_id,
    input  wire logic [NUM_GROUPS-1:0][TT_W-1:0]       grp_ttype,
    input  wire logic [NUM_GROUPS-1:0][MQE_NP-1:0]     grp_mask,
    // egress side
    input  wire logic                                  cfg_favour_mc,
    input  wire logic [MQE_NP-1:0]                     eg_ready,
    output logic                                       eg_favour_mc,
    output logic      [MQE_NP-1:0]                     eg_req,
    output logic      [MQE_NP-1:0]                     eg_valid,
    output logic      [MQE_NP-1:0][DATA_W-1:0]         eg_data,
    output logic      [MQE_NP-1:0]                     eg_eop,
    output logic      [MQE_NP-1:0][PRIO_W-1:0]         eg_prio
);
    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [MQE_NP-1:0]              hit;                 // group match per port
    logic [MQE_NP-1:0][MQE_NP-1:0]  pvec;                // mask of first hit
    logic [MQE_NP-1:0]              elig;                // arbiter requests
    logic [MQE_NP-1:0]              arb_grant;           // arbiter pick
    logic [MQE_IDX_W-1:0]           arb_idx;             // arbiter pick index
    logic                           arb_any;             // something pending
    logic [PRIO_W-1:0]              arb_top;             // pending top priority
    logic [MQE_NP-1:0]              in_grant_reg;        // port now sending
    logic [MQE_IDX_W-1:0]           cur_idx_reg;         // index of that port
    logic [MQE_NP-1:0]              cur_vec_reg;         // its multicast vector
    logic [PRIO_W-1:0]              cur_prio_reg;        // its priority
    logic                           in_space_reg;        // room for a big packet
    logic [MQE_NP-1:0]              in_mc_hit_reg;       // steering answer
    logic                           busy, ending, take;  // ingress sequencing
    logic                           wq_wr_en, wq_wr_eop; // queue write
    logic                           wq_rd_en;            // queue read
    logic [DATA_W-1:0]              wq_mem [WQ_DEPTH_W]; // queue words
    logic [MQE_NP+PRIO_W:0]         wq_tag [WQ_DEPTH_W]; // eop, prio, vector
    logic [WQ_PTR_W-1:0]            wq_wr_ptr_reg;       // circular write
    logic [WQ_PTR_W-1:0]            wq_rd_ptr_reg;       // circular read
    logic [WQ_CNT_W-1:0]            wq_cnt_reg;          // words held
    logic [WQ_CNT_W-1:0]            wq_cnt_next;         // words after edge
    logic [MQE_NP-1:0]              head_vec;            // vector of head word
    logic [MQE_NP-1:0]              bb_space;            // buffer space flags
    logic                           bb_wr_valid_reg;     // word to buffers
    logic [DATA_W-1:0]              bb_wr_data_reg;      // its data
    logic                           bb_wr_eop_reg;       // its end flag
    logic [PRIO_W-1:0]              bb_wr_prio_reg;      // its priority
    logic [MQE_NP-1:0]              bb_wr_vec_reg;       // targeted buffers
    logic                           favour_reg;          // egress favour select

    ////////////////////////////////////////////////////////////////////////////
    // group lookup: a hit steers to the engine, a miss leaves lookup routing
    always_comb
    begin
        hit = '0;
        pvec = '0;
        for (int p = 0; p < MQE_NP; p++)
        begin
            for (int g = NUM_GROUPS - 1; g >= 0; g--)
            begin
                if (grp_valid[g] && grp_dest_id[g] == in_dest_id[p]
                    && grp_ttype[g] == in_ttype[p]) // RQ18 RQ19
                begin
                    hit[p]  = 1'b1;
                    pvec[p] = grp_mask[g];
                end
            end
        end
    end

    // steering answer per ingress port
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            in_mc_hit_reg <= '0;
        else
            in_mc_hit_reg <= hit;
    end

    ////////////////////////////////////////////////////////////////////////////
    // ingress selection; only switch ingress ports may request
    assign busy      = |in_grant_reg;
    assign wq_wr_en  = busy && in_valid[cur_idx_reg];         // RQ1
    assign wq_wr_eop = in_eop[cur_idx_reg];
    assign ending    = wq_wr_en && wq_wr_eop;
    // a finishing port may ask again at once
    assign elig      = in_req & hit & ~(ending ? '0 : in_grant_reg);
    // next grant may land on the last word, so packets run back to back
    assign take      = (!busy || ending) && arb_any
                       && (WQ_DEPTH_C - wq_cnt_next) >= WQ_ROOM_C; // RQ7 RQ16 RQ15

    mqe_prio_arb u_arb (
        .ref_clk (ref_clk),
        .rst     (rst),
        .req     (elig),
        .prio    (in_prio),
        .take    (take),
        .grant   (arb_grant),
        .gidx    (arb_idx),
        .any     (arb_any),
        .top     (arb_top)
    ); // RQ2

    // grant holds for a whole packet
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            in_grant_reg <= '0;
            cur_idx_reg  <= '0;
            cur_vec_reg  <= '0;
            cur_prio_reg <= '0;
        end
        else if (take)
        begin
            in_grant_reg <= arb_grant;
            cur_idx_reg  <= arb_idx;
            cur_vec_reg  <= pvec[arb_idx] & ~arb_grant; // RQ20
            cur_prio_reg <= in_prio[arb_idx];
        end
        else if (ending)
            in_grant_reg <= '0;
    end

    // room flag shown to every ingress port, one level for all priorities
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            in_space_reg <= 1'b0;
        else
            in_space_reg <= (WQ_DEPTH_C - wq_cnt_next) >= WQ_ROOM_C; // RQ7
    end

    ////////////////////////////////////////////////////////////////////////////
    // work queue: circular store, head read as soon as a word is in
    assign head_vec    = wq_tag[wq_rd_ptr_reg][MQE_NP-1:0];
    assign wq_rd_en    = wq_cnt_reg != '0 && (head_vec & ~bb_space) == '0; // RQ4 RQ24
    assign wq_cnt_next = wq_cnt_reg + WQ_CNT_W'(wq_wr_en) - WQ_CNT_W'(wq_rd_en); // RQ6

    // word storage at any position of the ring
    always_ff @(posedge ref_clk)
    begin
        if (wq_wr_en)
        begin
            wq_mem[wq_wr_ptr_reg] <= in_data[cur_idx_reg];
            wq_tag[wq_wr_ptr_reg] <= {wq_wr_eop, cur_prio_reg, cur_vec_reg};
        end
    end

    // ring pointers and occupancy
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wq_wr_ptr_reg <= '0;
            wq_rd_ptr_reg <= '0;
            wq_cnt_reg    <= '0;
        end
        else
        begin
            if (wq_wr_en) // RQ5
                wq_wr_ptr_reg <= (wq_wr_ptr_reg == WQ_LAST_C) ? '0
                                 : wq_wr_ptr_reg + 9'h001;
            if (wq_rd_en) // RQ3 RQ13
                wq_rd_ptr_reg <= (wq_rd_ptr_reg == WQ_LAST_C) ? '0
                                 : wq_rd_ptr_reg + 9'h001;
            wq_cnt_reg <= wq_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // one word stage drives every targeted buffer in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            bb_wr_valid_reg <= 1'b0;
            bb_wr_data_reg  <= '0;
            bb_wr_eop_reg   <= 1'b0;
            bb_wr_prio_reg  <= '0;
            bb_wr_vec_reg   <= '0;
        end
        else
        begin
            bb_wr_valid_reg <= wq_rd_en; // RQ22
            bb_wr_data_reg  <= wq_mem[wq_rd_ptr_reg];
            bb_wr_eop_reg   <= wq_rd_en && wq_tag[wq_rd_ptr_reg][MQE_NP+PRIO_W];
            bb_wr_prio_reg  <= wq_tag[wq_rd_ptr_reg][MQE_NP+PRIO_W-1:MQE_NP];
            bb_wr_vec_reg   <= head_vec;
        end
    end

    // broadcast buffers, fed from the queue and nothing else
    for (genvar p = 0; p < MQE_NP; p++)
    begin : g_bb
        mqe_bcast_buf u_bb (
            .ref_clk  (ref_clk),
            .rst      (rst),
            .wr_valid (bb_wr_valid_reg && bb_wr_vec_reg[p]), // RQ8
            .wr_data  (bb_wr_data_reg),
            .wr_eop   (bb_wr_eop_reg),
            .wr_prio  (bb_wr_prio_reg),
            .pend     (wq_rd_en && head_vec[p]),
            .space    (bb_space[p]),
            .eg_ready (eg_ready[p]),
            .eg_req   (eg_req[p]),
            .eg_valid (eg_valid[p]),
            .eg_data  (eg_data[p]),
            .eg_eop   (eg_eop[p]),
            .eg_prio  (eg_prio[p])
        );
    end

    // egress favour select, passed with the copy priority
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            favour_reg <= 1'b0;
        else
            favour_reg <= cfg_favour_mc; // RQ21
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign in_mc_hit    = in_mc_hit_reg;
    assign in_grant     = in_grant_reg;
    assign in_space_ok  = in_space_reg;
    assign eg_favour_mc = favour_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_one_sender;
        @(posedge ref_clk) disable iff (rst)
        $onehot0(in_grant_reg);
    endproperty
    a_one_sender : assert property (p_one_sender) else $error("two ports granted"); // RQ2

    property p_strict_prio;
        @(posedge ref_clk) disable iff (rst)
        take |=> in_prio[cur_idx_reg] == $past(arb_top);
    endproperty
    a_strict_prio : assert property (p_strict_prio) else $error("lower priority won"); // RQ2

    property p_capacity;
        @(posedge ref_clk) disable iff (rst)
        wq_cnt_reg <= WQ_DEPTH_C;
    endproperty
    a_capacity : assert property (p_capacity) else $error("work queue overrun"); // RQ6

    property p_room_flag;
        @(posedge ref_clk) disable iff (rst)
        in_space_reg |-> (WQ_DEPTH_C - wq_cnt_reg) >= WQ_ROOM_C;
    endproperty
    a_room_flag : assert property (p_room_flag) else $error("room shown without room"); // RQ7

    property p_ring_count;
        @(posedge ref_clk) disable iff (rst)
        (wq_wr_en && !wq_rd_en) |=> wq_cnt_reg == $past(wq_cnt_reg) + 9'h001;
    endproperty
    a_ring_count : assert property (p_ring_count) else $error("count lost a word"); // RQ5

    property p_cut_through;
        @(posedge ref_clk) disable iff (rst)
        (wq_wr_en && !wq_wr_eop && wq_cnt_reg == '0)
            |=> ((&bb_space) |-> ##1 bb_wr_valid_reg);
    endproperty
    a_cut_through : assert property (p_cut_through) else $error("no cut-through"); // RQ4

    property p_no_echo;
        @(posedge ref_clk) disable iff (rst)
        busy |-> (in_grant_reg & cur_vec_reg) == '0;
    endproperty
    a_no_echo : assert property (p_no_echo) else $error("copy aimed at source"); // RQ20

    property p_all_ready;
        @(posedge ref_clk) disable iff (rst)
        bb_wr_eop_reg |=> (eg_req & $past(bb_wr_vec_reg)) == $past(bb_wr_vec_reg);
    endproperty
    a_all_ready : assert property (p_all_ready) else $error("copies not ready together"); // RQ23

    property p_back_to_back;
        @(posedge ref_clk) disable iff (rst)
        (ending && (elig != '0) && in_space_reg && wq_cnt_reg < 9'h0C8) |=> busy;
    endproperty
    a_back_to_back : assert property (p_back_to_back) else $error("gap between packets"); // RQ16

    property p_pause;
        @(posedge ref_clk) disable iff (rst)
        (wq_cnt_reg != '0 && (head_vec & ~bb_space) != '0) |=> !bb_wr_valid_reg;
    endproperty
    a_pause : assert property (p_pause) else $error("sent to full buffer"); // RQ24

    c_b2b   : cover property (@(posedge ref_clk) disable iff (rst) ending && take);
    c_multi : cover property (@(posedge ref_clk) disable iff (rst)
        bb_wr_eop_reg && $countones(bb_wr_vec_reg) > 1);
    c_full  : cover property (@(posedge ref_clk) disable iff (rst) !in_space_reg);
endmodule
`default_nettype wire

/* rtl/mqe_pkg.sv */
// shared constants of the multicast replication engine
package mqe_pkg;
    // port and field widths
    localparam int MQE_NP      = 4;   // switch ports
    localparam int MQE_IDX_W   = 2;   // port index width
    localparam int DATA_W      = 64;  // one storage word
    localparam int DID_W       = 16;  // destination id
    localparam int TT_W        = 2;   // transaction type
    localparam int PRIO_W      = 2;   // packet priority
    localparam int NUM_GROUPS  = 8;   // destination id / type combinations
    // packet sizing
    localparam int WORD_BYTES    = 8;
    localparam int MAX_PKT_BYTES = 276;
    localparam int MAX_PKT_W     = (MAX_PKT_BYTES + WORD_BYTES - 1) / WORD_BYTES;
    // work queue sizing: 7 largest or 245 smallest packets
    localparam int WQ_MAX_PKTS = 7;
    localparam int WQ_MIN_PKTS = 245;
    localparam int WQ_DEPTH_W  = WQ_MIN_PKTS + MAX_PKT_W - 1;
    localparam int WQ_PTR_W    = 9;
    localparam int WQ_CNT_W    = 9;
    localparam logic [WQ_CNT_W-1:0] WQ_DEPTH_C = WQ_CNT_W'(WQ_DEPTH_W);
    localparam logic [WQ_CNT_W-1:0] WQ_ROOM_C  = WQ_CNT_W'(MAX_PKT_W);
    localparam logic [WQ_PTR_W-1:0] WQ_LAST_C  = WQ_PTR_W'(WQ_DEPTH_W - 1);
    // broadcast buffer sizing
    localparam int BB_LIMIT_BYTES = 280;
    localparam int BB_DEPTH_W     = BB_LIMIT_BYTES / WORD_BYTES;
    localparam int BB_MAX_PKTS    = 8;
    localparam int BB_PTR_W       = 6;
    localparam int BB_PKT_W       = 4;
    localparam logic [BB_PTR_W-1:0] BB_DEPTH_C = BB_PTR_W'(BB_DEPTH_W);
    localparam logic [BB_PTR_W-1:0] BB_LAST_C  = BB_PTR_W'(BB_DEPTH_W - 1);
    localparam logic [BB_PTR_W-1:0] BB_ROOM_C  = 6'h01;
    localparam logic [BB_PKT_W-1:0] BB_PKTS_C  = BB_PKT_W'(BB_MAX_PKTS);
endpackage

/* rtl/mqe_prio_arb.sv */
// strict priority arbiter with round robin inside each priority
`timescale 1ns/1ps
`default_nettype none
module mqe_prio_arb
    import mqe_pkg::*;
(
    // clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    // requests
    input  wire logic [MQE_NP-1:0]             req,
    input  wire logic [MQE_NP-1:0][PRIO_W-1:0] prio,
    input  wire logic                          take,
    // decision
    output logic      [MQE_NP-1:0]             grant,
    output logic      [MQE_IDX_W-1:0]          gidx,
    output logic                               any,
    output logic      [PRIO_W-1:0]             top
);
    // last winner per priority level
    logic [(1<<PRIO_W)-1:0][MQE_IDX_W-1:0] last_reg;

    // highest pending priority, then rotate from last winner
    always_comb
    begin
        int j;
        logic found;
        j = 0;
        found = 1'b0;
        any = 1'b0;
        top = '0;
        grant = '0;
        gidx = '0;
        for (int i = 0; i < MQE_NP; i++)
        begin
            if (req[i])
            begin
                any = 1'b1;
                if (prio[i] > top)
                    top = prio[i];
            end
        end
        for (int k = 1; k <= MQE_NP; k++)
        begin
            j = (int'(last_reg[top]) + k) % MQE_NP;
            if (!found && req[j] && prio[j] == top)
            begin
                found = 1'b1;
                grant[j] = 1'b1;
                gidx = MQE_IDX_W'(j);
            end
        end
    end

    // remember the winner of the served level
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            last_reg <= '0;
        else if (take && any)
            last_reg[top] <= gidx;
    end
endmodule
`default_nettype wire

/* test/mqe_egress_model.sv */
// egress port model that drains broadcast copies and tallies them
`timescale 1ns/1ps
`default_nettype none
module mqe_egress_model
    import mqe_pkg::*;
(
    // clock, reset and stall request
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire logic                          hold,
    // copies from the engine
    input  wire logic [MQE_NP-1:0]             eg_valid,
    input  wire logic [MQE_NP-1:0][DATA_W-1:0] eg_data,
    input  wire logic [MQE_NP-1:0]             eg_eop,
    // flow control and tallies
    output logic      [MQE_NP-1:0]             eg_ready,
    output logic      [MQE_NP-1:0][7:0]        n_pkt,
    output logic      [MQE_NP-1:0][DATA_W-1:0] last
);
    // ready is a registered copy of ~hold, so a stall can pause a copy mid-packet
    always_ff @(posedge ref_clk)
    begin
        eg_ready <= rst ? '0 : {MQE_NP{~hold}};
        for (int p = 0; p < MQE_NP; p++)
        begin
            if (rst)
                n_pkt[p] <= '0;
            else if (eg_valid[p] && eg_eop[p])
                n_pkt[p] <= n_pkt[p] + 8'h01;
            if (eg_valid[p])
                last[p] <= eg_data[p];
        end
    end
endmodule
`default_nettype wire

/* test/mqe_engine_tb_top.sv */
// self-checking bench for the multicast replication engine
`timescale 1ns/1ps
`default_nettype none
module mqe_engine_tb_top;
    import mqe_pkg::*;
    // stimulus and observed signals
    logic                              ref_clk, rst, hold, fav, fav_o, sp_ok;
    logic [MQE_NP-1:0]                 req, vld, eop, hit, gnt, rdy, ereq, evld, eeop;
    logic [MQE_NP-1:0][PRIO_W-1:0]     pri, epr;
    logic [MQE_NP-1:0][DID_W-1:0]      did;
    logic [MQE_NP-1:0][TT_W-1:0]       tt;
    logic [MQE_NP-1:0][DATA_W-1:0]     dat, edat, last;
    logic [MQE_NP-1:0][7:0]            npk;
    logic [NUM_GROUPS-1:0]             gv;
    logic [NUM_GROUPS-1:0][DID_W-1:0]  gd;
    logic [NUM_GROUPS-1:0][TT_W-1:0]   gt;
    logic [NUM_GROUPS-1:0][MQE_NP-1:0] gm;
    int                                n_errors, compares;
    mqe_engine i_dut (.ref_clk(ref_clk), .rst(rst), .in_req(req), .in_prio(pri),
        .in_dest_id(did), .in_ttype(tt), .in_valid(vld), .in_data(dat), .in_eop(eop),
        .in_mc_hit(hit), .in_grant(gnt), .in_space_ok(sp_ok), .grp_valid(gv),
        .grp_dest_id(gd), .grp_ttype(gt), .grp_mask(gm), .cfg_favour_mc(fav),
        .eg_ready(rdy), .eg_favour_mc(fav_o), .eg_req(ereq), .eg_valid(evld),
        .eg_data(edat), .eg_eop(eeop), .eg_prio(epr));
    mqe_egress_model i_egr (.ref_clk(ref_clk), .rst(rst), .hold(hold), .eg_valid(evld),
        .eg_data(edat), .eg_eop(eeop), .eg_ready(rdy), .n_pkt(npk), .last(last));
    // free-running clock
    always #50 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////
    // compare, finish and drive helpers
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic hdr(input int p, input logic [1:0] pr);
        req[p] = 1'b1;
        pri[p] = pr;
        did[p] = 16'h00a5;
    endtask
    // wait for the grant, then stream n words, dropping the request with eop
    task automatic send(input int p, input int n, input int base);
        int k;
        k = 0;
        while (gnt[p] !== 1'b1 && k < 50)
        begin
            @(negedge ref_clk);
            k++;
        end
        if (k == 50)
        begin
            n_errors++;
            test_done();
        end
        for (int i = 0; i < n; i++)
        begin
            vld[p] = 1'b1;
            dat[p] = DATA_W'(base + i);
            eop[p] = (i == n - 1);
            req[p] = (i != n - 1);
            @(negedge ref_clk);
        end
        vld[p] = 1'b0;
        eop[p] = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        {ref_clk, rst, hold, fav, req, vld, eop, pri, did, dat, gv, gd, gt, gm} = '0;
        tt = {MQE_NP{2'h1}};
        rst = 1'b1;
        gv[2] = 1'b1;
        gd[2] = 16'h00a5;
        gt[2] = 2'h1;
        gm[2] = 4'hf;
        n_errors = 0;
        compares = 0;
        repeat (12) @(negedge ref_clk);
        rst = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(sp_ok, 1);
        fav = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk(fav_o, 1);
        $display("test space and favour done");
        // unmatched header is routed by lookup, then a match is steered
        hdr(3, 2'h0);
        did[3] = 16'h0011;
        repeat (4) @(negedge ref_clk);
        chk(hit[3], 0);
        chk(gnt, 0);
        did[3] = 16'h00a5;
        repeat (2) @(negedge ref_clk);
        chk(hit[3], 1);
        send(3, 1, 48);
        repeat (20) @(negedge ref_clk);
        chk(npk, 32'h0001_0101);
        $display("test steer done");
        // stalled egress: all copies complete before any is offered
        hold = 1'b1;
        hdr(0, 2'h1);
        send(0, 3, 256);
        repeat (12) @(negedge ref_clk);
        chk(ereq, 4'he);
        chk(evld, 0);
        chk(epr[1], 1);
        hold = 1'b0;
        repeat (20) @(negedge ref_clk);
        chk(npk, 32'h0102_0201);
        chk(last[1], 258);
        $display("test store done");
        // higher priority wins, then output keeps grant order
        hdr(1, 2'h1);
        hdr(2, 2'h3);
        repeat (3) @(negedge ref_clk);
        chk(gnt, 4'h4);
        send(2, 2, 512);
        send(1, 1, 768);
        repeat (30) @(negedge ref_clk);
        chk(npk[0], 3);
        chk(last[0], 768);
        $display("test priority done");
        // stalled egress lets the queue fill until a big packet no longer fits
        hold = 1'b1;
        repeat (8)
        begin
            hdr(0, 2'h1);
            send(0, MAX_PKT_W, 1024);
        end
        hdr(0, 2'h1);
        repeat (4) @(negedge ref_clk);
        chk(sp_ok, 0);
        chk(gnt, 0);
        req[0] = 1'b0;
        hold = 1'b0;
        repeat (900) @(negedge ref_clk);
        chk(sp_ok, 1);
        chk(npk, 32'h0b0b_0b03);
        $display("test full done");
        test_done();
    end
endmodule
`default_nettype wire
